// ### rtl/supply_threshold_detector.v
// Supply threshold detector: control register, flags and interrupt request
// Assumes a simple register port and comparator levels synchronous to mclk
//
// What this block does
// [RL1] Power detector only while enable bit set
// [RL2] Reference-stable flag reads zero until settled
// [RL3] No detect sets the flag while reference unstable
// [RL4] Direction bit selects falling or rising detect
// [RL5] Four-bit field picks one of sixteen levels
// [RL6] Code 1111 routes external input pin
// [RL7] Set flag on crossing when enabled, stable
// [RL8] Request only when flag and enable set
// [RL9] Software sets up in documented order
// [RL10] Software disables before changing settings
// [RL11] Read-only band gap stable flag bit 6
// [RL12] Reset clears control, detector off
// [RL13] Keeps detecting in sleep, requests wake
// [RL14] Counter models reference settle after enable
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`default_nettype none
`include "supply_detect_defs.vh"
module supply_threshold_detector #(
  parameter [`SETTLE_W-1:0] SETTLE_COUNT = `SETTLE_CYCLES
) (
  input  wire                mclk,
  input  wire                reset,
  input  wire [`ADDR_W-1:0]  addr,
  input  wire [7:0]          wdata,
  input  wire                wr_en,
  input  wire                rd_en,
  output reg  [7:0]          rdata_q,
  input  wire                bandgap_ok,
  input  wire                divider_below,
  input  wire                external_below,
  input  wire                sleeping,
  output wire                detector_power,
  output wire [3:0]          trip_level,
  output wire                external_select,
  output wire                irq,
  output wire                wake
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  localparam [7:0] CTL_RESET_VAL = `CTL_RESET;
  reg       direction_q;
  reg       enable_q;
  reg [3:0] level_q;
  reg       pending_q;
  reg       irq_en_q;
  reg       global_en_q;
  reg       bandgap_q;
  wire      ref_stable;
  wire      trip;
  wire      pending_d;
  wire [7:0] control_rd;

  function sel;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  always @(posedge mclk) begin
    if (reset) begin
      direction_q <= CTL_RESET_VAL[`CTL_DIR_BIT]; // see [RL12]
      enable_q    <= CTL_RESET_VAL[`CTL_EN_BIT];
      level_q     <= CTL_RESET_VAL[`CTL_LVL_HI:`CTL_LVL_LO];
      irq_en_q    <= 1'b0;
      global_en_q <= 1'b0;
      bandgap_q   <= 1'b0;
    end else begin
      bandgap_q <= bandgap_ok; // see [RL11]
      if (wr_en && sel(addr, `ADDR_CONTROL)) begin
        direction_q <= wdata[`CTL_DIR_BIT];
        enable_q    <= wdata[`CTL_EN_BIT];
        level_q     <= wdata[`CTL_LVL_HI:`CTL_LVL_LO]; // see [RL5]
      end
      if (wr_en && sel(addr, `ADDR_IRQ_EN)) begin
        irq_en_q    <= wdata[`PEND_BIT];
        global_en_q <= wdata[`IRQEN_GLOBAL_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settling and comparison
  assign detector_power  = enable_q; // see [RL1]
  assign trip_level      = level_q;

  reference_settle #(
    .SETTLE_COUNT (SETTLE_COUNT)
  ) u_settle (
    .mclk     (mclk),
    .reset    (reset),
    .enable   (enable_q),
    .stable_q (ref_stable)
  );

  trip_compare u_cmp (
    .mclk           (mclk),
    .reset          (reset),
    .armed          (enable_q && ref_stable), // see [RL3]
    .direction      (direction_q),
    .level          (level_q),
    .divider_below  (divider_below),
    .external_below (external_below),
    .trip_q         (trip),
    .use_external   (external_select)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pending flag: a detect wins over a software clear in the same cycle
  assign pending_d = (trip && enable_q && ref_stable) ? 1'b1 : // see [RL7]
                     (wr_en && sel(addr, `ADDR_PENDING)) ? wdata[`PEND_BIT] :
                     pending_q;

  always @(posedge mclk) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
    end
  end

  assign irq  = pending_q && irq_en_q && global_en_q; // see [RL8]
  // Detection is independent of sleep; a pending enabled flag wakes the core
  assign wake = sleeping && pending_q && irq_en_q; // see [RL13]

  ////////////////////////////////////////////////////////////////////////
  // Read port
  assign control_rd = {direction_q, bandgap_q, ref_stable, enable_q, level_q}; // see [RL2]

  always @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      if (sel(addr, `ADDR_CONTROL)) begin
        rdata_q <= control_rd;
      end else if (sel(addr, `ADDR_PENDING)) begin
        rdata_q <= {5'h00, pending_q, 2'h0};
      end else if (sel(addr, `ADDR_IRQ_EN)) begin
        rdata_q <= {global_en_q, 4'h0, irq_en_q, 2'h0};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### rtl/supply_detect_defs.vh
// Constants for the supply threshold detector control block
// Assumes inclusion by bare name from rtl design files
`ifndef SUPPLY_DETECT_DEFS_VH
`define SUPPLY_DETECT_DEFS_VH

// Register addresses (4-bit register port address)
`define ADDR_W              4
`define ADDR_CONTROL        4'h0
`define ADDR_PENDING        4'h1
`define ADDR_IRQ_EN         4'h2

// Control register fields
`define CTL_RESET           8'h00
`define CTL_DIR_BIT         7
`define CTL_BG_BIT          6
`define CTL_REF_BIT         5
`define CTL_EN_BIT          4
`define CTL_LVL_HI          3
`define CTL_LVL_LO          0
`define LVL_EXTERNAL        4'hF
`define LVL_MIN             4'h0

// Pending flag and its enable share bit position 2; the global enable is bit 7
`define PEND_BIT            2
`define IRQEN_GLOBAL_BIT    7

// Reference settle time in ns and derived cycle count at 40 ns per cycle
`define CLK_PERIOD_NS       40
`define SETTLE_NS           20000
`define SETTLE_CYCLES       ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W            16

`endif

// ### rtl/reference_settle.v
// Settling model for the internal reference of the detector
// Assumes enable is a register level synchronous to mclk
`default_nettype none
`include "supply_detect_defs.vh"
module reference_settle #(
  parameter [`SETTLE_W-1:0] SETTLE_COUNT = `SETTLE_CYCLES
) (
  input  wire mclk,
  input  wire reset,
  input  wire enable,
  output reg  stable_q
);

  reg [`SETTLE_W-1:0] count_q;

  // Count restarts on every enable, flag drops on the first mclk edge with enable low
  always @(posedge mclk) begin
    if (reset || !enable) begin
      count_q  <= {`SETTLE_W{1'b0}};
      stable_q <= 1'b0;
    end else if (!stable_q) begin
      if (count_q >= SETTLE_COUNT - 1'b1) begin // see [RL14]
        stable_q <= 1'b1; // see [RL2]
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/trip_compare.v
// Trip input selection and direction-qualified detection
// Assumes comparator levels are already synchronous to mclk
`default_nettype none
module trip_compare (
  input  wire       mclk,
  input  wire       reset,
  input  wire       armed,
  input  wire       direction,
  input  wire [3:0] level,
  input  wire       divider_below,
  input  wire       external_below,
  output reg        trip_q,
  output wire       use_external
);
`include "supply_detect_defs.vh"

  wire below;
  wire hit;

  assign use_external = (level == `LVL_EXTERNAL); // see [RL6]
  assign below        = use_external ? external_below : divider_below;
  // Falling detect trips at or below, rising strictly above
  assign hit          = direction ? !below : below; // see [RL4]

  always @(posedge mclk) begin
    if (reset || !armed) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= hit;
    end
  end

endmodule
`default_nettype wire

// ### testbench/analog_model.sv
// Comparator and divider model at the analog side of the detector
// Assumes millivolt levels driven by the bench
`default_nettype none
module analog_model (
  input  wire logic [15:0] supply_mv,
  input  wire logic [15:0] ext_mv,
  input  wire logic [3:0]  trip_level,
  input  wire logic        detector_power,
  output wire logic        divider_below,
  output wire logic        external_below
);
  timeunit 1ns;
  timeprecision 1ps;
  // Trip points climb 100 mV a code from 1000 mV; an unpowered comparator stays low
  assign divider_below = detector_power && supply_mv <= 16'h03E8 + 16'h0064 * trip_level;
  assign external_below = detector_power && ext_mv <= 16'h04B0;
endmodule
`default_nettype wire

// ### testbench/detector_monitor.sv
// Checker on the ports of the detector control block
// Assumes a bind onto supply_threshold_detector
`default_nettype none
module detector_monitor #(parameter [15:0] SETTLE_COUNT = 16'h01F4) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata_q,
  input wire logic       sleeping,
  input wire logic       detector_power,
  input wire logic [3:0] trip_level,
  input wire logic       external_select,
  input wire logic       irq,
  input wire logic       wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (reset);
  wire ctl_wr = wr_en && addr == 4'h0;
  chk_power_write: assert property (ctl_wr |=> detector_power == $past(wdata[4])) else $error("power");
  chk_power_hold: assert property (!ctl_wr |=> $stable(detector_power)) else $error("hold");
  chk_level_write: assert property (ctl_wr |=> trip_level == $past(wdata[3:0])) else $error("level");
  chk_ext_route: assert property (external_select == (trip_level == 4'hF)) else $error("route");
  chk_reset_clear: assert property ($past(reset) |-> !detector_power && !irq && trip_level == 4'h0)
    else $error("reset");
  chk_irq_armed: assert property ($rose(irq) && !$past(wr_en) |-> $past(detector_power, 2))
    else $error("irq");
  chk_wake_sleep: assert property (wake |-> sleeping) else $error("wake");
  chk_read_ctl: assert property (rd_en && addr == 4'h0 |=> rdata_q[4:0] == {detector_power, trip_level})
    else $error("read");
endmodule
bind supply_threshold_detector detector_monitor #(.SETTLE_COUNT(SETTLE_COUNT)) u_detector_monitor (.mclk, .reset,
  .addr, .wdata, .wr_en, .rd_en, .rdata_q, .sleeping, .detector_power, .trip_level, .external_select, .irq, .wake);
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the supply threshold detector
// Assumes the analog model and the bound checker
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, bandgap_ok = 1'b1, sleeping = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic [15:0] supply_mv = 16'h0384, ext_mv = 16'h07D0;
  wire  [7:0]  rdata_q;
  wire  [3:0]  trip_level;
  wire         divider_below, external_below, detector_power, external_select, irq, wake;
  int          fail_count = 0, checked = 0;
  always #20 mclk = ~mclk;
  supply_threshold_detector #(.SETTLE_COUNT(16'h0004)) u_supply_threshold_detector (.mclk, .reset, .addr, .wdata,
    .wr_en, .rd_en, .rdata_q, .bandgap_ok, .divider_below, .external_below, .sleeping, .detector_power,
    .trip_level, .external_select, .irq, .wake);
  analog_model u_analog_model (.supply_mv, .ext_mv, .trip_level, .detector_power, .divider_below, .external_below);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) begin wr_en <= 1'b1; addr <= a; wdata <= d; end
    @(posedge mclk) wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk) begin rd_en <= 1'b1; addr <= a; end
    @(posedge mclk) rd_en <= 1'b0;
    #1 chk(rdata_q, e);
  endtask
  task automatic t_settle;
    wr(4'h0, 8'h03);
    wr(4'h0, 8'h13);
    rd(4'h0, 8'h53);
    rd(4'h1, 8'h00);
    repeat (6) @(posedge mclk);
    rd(4'h0, 8'h73);
    rd(4'h1, 8'h04);
    wr(4'h2, 8'h84);
    chk({7'h00, irq}, 8'h01);
    @(posedge mclk) supply_mv <= 16'h07D0;
    repeat (3) @(posedge mclk);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h00);
    chk({7'h00, irq}, 8'h00);
    @(posedge mclk) supply_mv <= 16'h0384;
    repeat (4) @(posedge mclk);
    #1 chk({7'h00, irq}, 8'h01);
    @(posedge mclk) supply_mv <= 16'h07D0;
    repeat (3) @(posedge mclk);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
  endtask
  task automatic t_rise;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h93);
    repeat (10) @(posedge mclk);
    rd(4'h1, 8'h04);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
  endtask
  task automatic t_ext;
    wr(4'h0, 8'h1F);
    chk({7'h00, external_select}, 8'h01);
    repeat (10) @(posedge mclk);
    rd(4'h1, 8'h00);
    @(posedge mclk) begin ext_mv <= 16'h03E8; sleeping <= 1'b1; end
    repeat (10) @(posedge mclk);
    rd(4'h1, 8'h04);
    wr(4'h2, 8'h04);
    chk({7'h00, wake}, 8'h01);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_ro;
    @(posedge mclk) bandgap_ok <= 1'b0;
    wr(4'h0, 8'h60);
    rd(4'h0, 8'h00);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd(4'h0, 8'h40);
    rd(4'h2, 8'h00);
    t_settle;
    t_rise;
    t_ext;
    t_ro;
    finish_test;
  end
  initial begin
    #20000;
    fail_count++;
    finish_test;
  end
endmodule
`default_nettype wire
